/* File: psc_privilege_state_control.sv */
// psc_privilege_state_control: processing state, privilege level, stack
// selection and access space code of the core, with a wishbone register port.
// assumes core event pins are synchronous one-cycle pulses on clk.
//
// Summary of operation
// - core is always in exactly one of normal, exception or halted.
// - interrupt, trace, trap or bus fault events start exception processing.
// - exception state spans stacking, vector fetch and pipe refill.
// - exception ends when the handler's first instruction begins.
// - bus or address error during exception processing halts the core.
// - halted core leaves only by external reset.
// - stop instruction gives a stopped normal state with no bus cycles.
// - supervisor flag set means supervisor privilege, all instructions run.
// - supervisor instructions carry supervisor access space codes.
// - supervisor with master flag uses the master stack pointer.
// - supervisor without master flag uses the interrupt stack pointer.
// - after reset the core is supervisor, interrupt mode, master clear.
// - master flag does not affect privileged instruction execution.
// - only the five status-writing ops and interrupt entry alter the master flag.
// - interrupt exceptions save then clear the master flag.
// - exception processing runs supervisor with supervisor bus cycles.
// - supervisor flag clear means user privilege.
// - user level may not stop, reset or alter the supervisor flag.
// - software trap gives users controlled entry to the supervisor.
// - user instructions carry user access space codes.
// - user level stack references use the user stack pointer.
// - access space codes 001, 010, 101, 110 and 111 as defined.
// - exception entry saves the status word, then sets supervisor.
// - privileged op at user level raises a privilege violation.
`timescale 1ns/10ps
module psc_privilege_state_control (
   input wire logic clk,
   input wire logic reset,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [3:0] wbSel,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   input wire logic intAckIn,
   input wire logic traceIn,
   input wire logic trapIn,
   input wire logic busErrorIn,
   input wire logic addrErrorIn,
   input wire logic handlerStartIn,
   input wire logic progFetchIn,
   input wire logic cpuSpaceIn,
   output logic [2:0] accessSpaceCode,
   output logic busCycleEn,
   output logic supervisorOut,
   output logic exceptionOut,
   output logic haltedOut,
   output logic stoppedOut,
   output logic privViolationOut,
   output logic resetDevicesOut,
   output logic [1:0] activeStackOut
);
   import psc_pkg::*;

   psc_state_t stateQ;
   logic [15:0] swQ;
   logic [15:0] savedSwQ;
   logic [CAUSE_W-1:0] causeQ;
   logic stoppedQ;
   logic ackQ;
   logic privQ;
   logic rstDevQ;
   logic [2:0] fcQ;

   logic isSuper;
   logic isMaster;
   logic access;
   logic wrEn;
   logic cmdTake;
   logic [3:0] cmdOp;
   logic [15:0] cmdArg;
   logic cmdPriv;
   logic privViol;
   logic softTrap;
   logic hwExc;
   logic excEnter;
   logic excFault;
   logic cmdRun;
   logic spSel;
   logic [1:0] activeSp;
   logic [31:0] rdMux;

   psc_sp_if spIf ();

   psc_stack_bank uBank (
      .clk(clk),
      .reset(reset),
      .port(spIf.bank)
   );

   // privilege follows the status word alone
   assign isSuper = swQ[SW_SUPER_BIT];
   assign isMaster = swQ[SW_MASTER_BIT];

   // bus qualifiers: a write takes effect at the edge where ack is high
   assign access = wbCyc & wbStb;
   assign wrEn = access & wbWe & ackQ;

   // commands stand for executed instructions; only full-word writes count
   assign cmdOp = wbDatIn[CMD_OP_LSB +: 4];
   assign cmdArg = wbDatIn[15:0];
   assign cmdTake = wrEn && wbAdr == ADR_COMMAND && wbSel == 4'hF
      && stateQ == ST_NORMAL && !stoppedQ;

   // the master flag plays no part here, only the supervisor flag
   always_comb begin
      case (cmdOp)
         OP_MOVE_TO_STATUS, OP_AND_TO_STATUS, OP_XOR_TO_STATUS,
         OP_OR_TO_STATUS, OP_RETURN_FROM_EXC, OP_STOP_WAIT,
         OP_RESET_DEVICES: cmdPriv = 1'b1;
         default: cmdPriv = 1'b0;
      endcase
   end

   assign privViol = cmdTake & cmdPriv & ~isSuper;
   assign softTrap = cmdTake && cmdOp == OP_SOFT_TRAP;

   // event sources that pre-empt normal processing
   assign hwExc = intAckIn | traceIn | trapIn | busErrorIn | addrErrorIn;
   assign excEnter = stateQ == ST_NORMAL
      && (hwExc | privViol | softTrap);
   assign excFault = stateQ == ST_EXCEPTION
      && (busErrorIn | addrErrorIn);

   // an instruction only runs if no exception takes the same cycle
   assign cmdRun = cmdTake & ~excEnter;

   // active stack: user, else master or interrupt by the master flag
   always_comb begin
      if (!isSuper) begin
         activeSp = SP_IDX_USER;
      end else if (isMaster) begin
         activeSp = SP_IDX_MASTER;
      end else begin
         activeSp = SP_IDX_INT;
      end
   end

   // processing state machine; halted is left only through reset
   always_ff @(posedge clk) begin
      if (reset) begin
         stateQ <= ST_NORMAL;
      end else begin
         case (stateQ)
            ST_NORMAL: begin
               if (excEnter) begin
                  stateQ <= ST_EXCEPTION;
               end
            end
            ST_EXCEPTION: begin
               // stacking, vector fetch and refill all stay in here
               if (excFault) begin
                  stateQ <= ST_HALTED;
               end else if (handlerStartIn) begin
                  stateQ <= ST_NORMAL;
               end
            end
            ST_HALTED: stateQ <= ST_HALTED;
            default: stateQ <= ST_HALTED;
         endcase
      end
   end

   // status word: entry forces supervisor, interrupts drop the master flag
   always_ff @(posedge clk) begin
      if (reset) begin
         swQ <= SW_RESET;
      end else if (excEnter) begin
         swQ[SW_SUPER_BIT] <= 1'b1;
         if (intAckIn) begin
            swQ[SW_MASTER_BIT] <= 1'b0;
         end
      end else if (cmdRun) begin
         case (cmdOp)
            OP_MOVE_TO_STATUS: swQ <= cmdArg;
            OP_AND_TO_STATUS: swQ <= swQ & cmdArg;
            OP_XOR_TO_STATUS: swQ <= swQ ^ cmdArg;
            OP_OR_TO_STATUS: swQ <= swQ | cmdArg;
            OP_RETURN_FROM_EXC: swQ <= cmdArg;
            default: swQ <= swQ;
         endcase
      end
   end

   // frame copy of the status word and the cause, taken before any change
   always_ff @(posedge clk) begin
      if (reset) begin
         savedSwQ <= 16'h0000;
         causeQ <= '0;
      end else if (excEnter) begin
         savedSwQ <= swQ;
         causeQ[CAUSE_INT] <= intAckIn;
         causeQ[CAUSE_TRACE] <= traceIn;
         causeQ[CAUSE_TRAP] <= trapIn;
         causeQ[CAUSE_BUS] <= busErrorIn;
         causeQ[CAUSE_ADDR] <= addrErrorIn;
         causeQ[CAUSE_PRIV] <= privViol;
         causeQ[CAUSE_SOFT] <= softTrap;
      end
   end

   // stopped is a flavour of normal; any exception wakes it
   always_ff @(posedge clk) begin
      if (reset) begin
         stoppedQ <= 1'b0;
      end else if (excEnter) begin
         stoppedQ <= 1'b0;
      end else if (cmdRun && cmdOp == OP_STOP_WAIT) begin
         stoppedQ <= 1'b1;
      end
   end

   // one-cycle pulses for privilege violation and device reset
   always_ff @(posedge clk) begin
      if (reset) begin
         privQ <= 1'b0;
         rstDevQ <= 1'b0;
      end else begin
         privQ <= privViol;
         rstDevQ <= cmdRun && cmdOp == OP_RESET_DEVICES;
      end
   end

   // access space code; registered, so it lags the state by one cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         fcQ <= SPACE_SUPER_PROG;
      end else if (cpuSpaceIn) begin
         fcQ <= SPACE_CPU;
      end else if (isSuper || stateQ == ST_EXCEPTION) begin
         fcQ <= progFetchIn ? SPACE_SUPER_PROG
            : SPACE_SUPER_DATA;
      end else begin
         fcQ <= progFetchIn ? SPACE_USER_PROG
            : SPACE_USER_DATA;
      end
   end

   // no bus cycles while stopped or halted
   assign busCycleEn = (stateQ == ST_NORMAL && !stoppedQ)
      || stateQ == ST_EXCEPTION;

   // wishbone ack: one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk) begin
      if (reset) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= access & ~ackQ;
      end
   end

   // stack bank access; the alias follows whichever pointer is active
   always_comb begin
      spSel = 1'b1;
      case (wbAdr)
         ADR_USER_STACK: spIf.idx = SP_IDX_USER;
         ADR_INT_STACK: spIf.idx = SP_IDX_INT;
         ADR_MASTER_STACK: spIf.idx = SP_IDX_MASTER;
         ADR_STACK_ALIAS: spIf.idx = activeSp;
         default: begin
            spIf.idx = activeSp;
            spSel = 1'b0;
         end
      endcase
   end

   assign spIf.we = wrEn & spSel;
   assign spIf.be = wbSel;
   assign spIf.wdata = wbDatIn;

   // read mux; unmapped addresses read zero and are still acknowledged
   always_comb begin
      rdMux = 32'h0000_0000;
      case (wbAdr)
         ADR_STATUS_WORD: rdMux[15:0] = swQ;
         ADR_STATE: begin
            rdMux[2:0] = stateQ;
            rdMux[ST_STOPPED_BIT] = stoppedQ;
            rdMux[ST_SUPER_BIT] = isSuper;
            rdMux[ST_MASTER_BIT] = isMaster;
            rdMux[ST_CAUSE_LSB +: CAUSE_W] = causeQ;
         end
         ADR_SAVED_STATUS: rdMux[15:0] = savedSwQ;
         ADR_USER_STACK, ADR_INT_STACK, ADR_MASTER_STACK,
         ADR_STACK_ALIAS: rdMux = spIf.rdata;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // outputs
   assign wbDatOut = rdMux;
   assign wbAck = ackQ;
   assign accessSpaceCode = fcQ;
   assign supervisorOut = isSuper;
   assign exceptionOut = stateQ == ST_EXCEPTION;
   assign haltedOut = stateQ == ST_HALTED;
   assign stoppedOut = stoppedQ;
   assign privViolationOut = privQ;
   assign resetDevicesOut = rstDevQ;
   assign activeStackOut = activeSp;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_ONE_STATE: assert property (
      $onehot(stateQ))
      else $error("state is not one-hot");

   AST_FAULT_HALTS: assert property (
      stateQ == ST_EXCEPTION && (busErrorIn || addrErrorIn)
      |=> stateQ == ST_HALTED)
      else $error("fault in exception did not halt");

   AST_HALT_STICKY: assert property (
      stateQ == ST_HALTED |=> stateQ == ST_HALTED && !busCycleEn)
      else $error("halted state left without reset");

   AST_HANDLER_ENDS: assert property (
      stateQ == ST_EXCEPTION && handlerStartIn && !busErrorIn
      && !addrErrorIn |=> stateQ == ST_NORMAL)
      else $error("handler start did not end exception");

   AST_STOP_NO_BUS: assert property (
      cmdRun && cmdOp == OP_STOP_WAIT |=> stoppedQ && !busCycleEn
      && stateQ == ST_NORMAL)
      else $error("stop still issues bus cycles");

   AST_EXC_SUPER_SPACE: assert property (
      $past(stateQ) == ST_EXCEPTION && !$past(reset)
      |-> accessSpaceCode[2] && isSuper)
      else $error("exception cycle not supervisor");

   AST_USER_SPACE: assert property (
      !$past(isSuper) && $past(stateQ) == ST_NORMAL && !$past(cpuSpaceIn)
      && !$past(reset)
      |-> accessSpaceCode == SPACE_USER_DATA
      || accessSpaceCode == SPACE_USER_PROG)
      else $error("user cycle without user space code");

   AST_ENTRY_SAVE: assert property (
      excEnter |=> savedSwQ == $past(swQ) && isSuper
      && stateQ == ST_EXCEPTION)
      else $error("status not saved on exception entry");

   AST_INT_CLEARS_MASTER: assert property (
      excEnter && intAckIn |=> !isMaster && activeSp == SP_IDX_INT)
      else $error("interrupt entry kept master flag");

   AST_PRIV_VIOL: assert property (
      cmdTake && cmdPriv && !isSuper |=> privViolationOut
      && stateQ == ST_EXCEPTION && $stable(stoppedQ))
      else $error("privileged op at user level not trapped");

   AST_MASTER_ONLY_OPS: assert property (
      $changed(isMaster) && !$past(reset) |-> $past(cmdRun || excEnter))
      else $error("master flag changed by other means");

   AST_RESET_MODE: assert property (
      $past(reset) |-> isSuper && !isMaster && stateQ == ST_NORMAL)
      else $error("reset did not give interrupt mode");

endmodule : psc_privilege_state_control

/* File: psc_pkg.sv */
// psc_pkg: constants and types shared by the privilege and state control
// block and its stack pointer bank.
// assumes a 32-bit classic wishbone slave with byte addresses.
package psc_pkg;

   // register byte addresses
   localparam logic [7:0] ADR_STATUS_WORD = 8'h00;
   localparam logic [7:0] ADR_COMMAND = 8'h04;
   localparam logic [7:0] ADR_STATE = 8'h08;
   localparam logic [7:0] ADR_SAVED_STATUS = 8'h0C;
   localparam logic [7:0] ADR_USER_STACK = 8'h10;
   localparam logic [7:0] ADR_INT_STACK = 8'h14;
   localparam logic [7:0] ADR_MASTER_STACK = 8'h18;
   localparam logic [7:0] ADR_STACK_ALIAS = 8'h1C;

   // status word layout and reset value (supervisor, interrupt mode)
   localparam int SW_SUPER_BIT = 13;
   localparam int SW_MASTER_BIT = 12;
   localparam logic [15:0] SW_RESET = 16'h2700;

   // command register: opcode field above a 16-bit operand
   localparam int CMD_OP_LSB = 16;
   localparam logic [3:0] OP_MOVE_TO_STATUS = 4'h1;
   localparam logic [3:0] OP_AND_TO_STATUS = 4'h2;
   localparam logic [3:0] OP_XOR_TO_STATUS = 4'h3;
   localparam logic [3:0] OP_OR_TO_STATUS = 4'h4;
   localparam logic [3:0] OP_RETURN_FROM_EXC = 4'h5;
   localparam logic [3:0] OP_STOP_WAIT = 4'h6;
   localparam logic [3:0] OP_RESET_DEVICES = 4'h7;
   localparam logic [3:0] OP_SOFT_TRAP = 4'h8;

   // state register field positions
   localparam int ST_STOPPED_BIT = 3;
   localparam int ST_SUPER_BIT = 4;
   localparam int ST_MASTER_BIT = 5;
   localparam int ST_CAUSE_LSB = 8;

   // exception cause bits captured on entry
   localparam int CAUSE_W = 7;
   localparam int CAUSE_INT = 0;
   localparam int CAUSE_TRACE = 1;
   localparam int CAUSE_TRAP = 2;
   localparam int CAUSE_BUS = 3;
   localparam int CAUSE_ADDR = 4;
   localparam int CAUSE_PRIV = 5;
   localparam int CAUSE_SOFT = 6;

   // access space codes
   localparam logic [2:0] SPACE_USER_DATA = 3'h1;
   localparam logic [2:0] SPACE_USER_PROG = 3'h2;
   localparam logic [2:0] SPACE_SUPER_DATA = 3'h5;
   localparam logic [2:0] SPACE_SUPER_PROG = 3'h6;
   localparam logic [2:0] SPACE_CPU = 3'h7;

   // stack pointer bank entries
   localparam int SP_COUNT = 3;
   localparam logic [1:0] SP_IDX_USER = 2'h0;
   localparam logic [1:0] SP_IDX_INT = 2'h1;
   localparam logic [1:0] SP_IDX_MASTER = 2'h2;

   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_EXCEPTION = 3'b010,
      ST_HALTED = 3'b100
   } psc_state_t;

endpackage : psc_pkg

/* File: psc_sp_if.sv */
// psc_sp_if: port between the control block and its stack pointer bank.
// assumes one access per cycle; read data arrive one cycle after idx.
`timescale 1ns/10ps
interface psc_sp_if;
   logic [1:0] idx;
   logic we;
   logic [3:0] be;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl (output idx, output we, output be, output wdata,
      input rdata);
   modport bank (input idx, input we, input be, input wdata,
      output rdata);
endinterface : psc_sp_if

/* File: psc_stack_bank.sv */
// psc_stack_bank: the three stack pointers, byte-writable, registered read.
// assumes idx never selects an entry above the master pointer.
`timescale 1ns/10ps
module psc_stack_bank (
   input wire logic clk,
   input wire logic reset,
   psc_sp_if.bank port
);
   import psc_pkg::*;

   // one storage column per byte lane so lane writes have a single driver
   for (genvar b = 0; b < 4; b++) begin : gLane
      logic [7:0] lane [SP_COUNT];
      logic [7:0] rdQ;

      always_ff @(posedge clk) begin
         if (port.we && port.be[b] && port.idx <= SP_IDX_MASTER) begin
            lane[port.idx] <= port.wdata[8*b +: 8];
         end
      end

      // read register; pointer contents are left to software after reset
      always_ff @(posedge clk) begin
         if (reset) begin
            rdQ <= 8'h00;
         end else if (port.idx <= SP_IDX_MASTER) begin
            rdQ <= lane[port.idx];
         end else begin
            rdQ <= 8'h00;
         end
      end

      assign port.rdata[8*b +: 8] = rdQ;
   end

endmodule : psc_stack_bank

/* File: psc_bus_partner.sv */
// psc_bus_partner: far-side bus system; marks program/cpu cycles and
// checks the space code of every cycle against the privilege it saw.
// assumes the code is registered one cycle behind its causes.
`timescale 1ns/10ps
module psc_bus_partner
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cpuReq,
   input wire logic supervisorIn,
   input wire logic exceptionIn,
   input wire logic [2:0] accessSpaceCode,
   output logic progFetch,
   output logic cpuSpace,
   output logic [15:0] codeErrs,
   output logic [15:0] codeChecks
);
   logic [2:0] expCode_q;
   logic valid_q;

   // counters survive a reset so that mid-run resets lose nothing
   initial begin
      progFetch = 1'b0;
      cpuSpace = 1'b0;
      codeErrs = 16'h0;
      codeChecks = 16'h0;
      valid_q = 1'b0;
      expCode_q = 3'h0;
   end

   // fetch flips every cycle so program and data codes both appear
   always @(posedge clk) begin
      progFetch <= reset ? 1'b0 : ~progFetch;
      cpuSpace <= cpuReq;
   end

   // expected code from last cycle's kind and privilege
   always @(posedge clk) begin
      if (reset) begin
         valid_q <= 1'b0;
      end else begin
         if (valid_q) begin
            codeChecks <= codeChecks + 16'h1;
            if (accessSpaceCode !== expCode_q) begin
               codeErrs <= codeErrs + 16'h1;
            end
         end
         valid_q <= 1'b1;
         if (cpuSpace) begin
            expCode_q <= SPACE_CPU;
         end else if (supervisorIn | exceptionIn) begin
            expCode_q <= progFetch ? SPACE_SUPER_PROG : SPACE_SUPER_DATA;
         end else begin
            expCode_q <= progFetch ? SPACE_USER_PROG : SPACE_USER_DATA;
         end
      end
   end
endmodule : psc_bus_partner

/* File: psc_privilege_state_control_bench.sv */
// psc_privilege_state_control_bench: self-checking bench for the state
// and privilege block; registers over wishbone, events as pulses.
// assumes the partner model drives the fetch and cpu-space pins.
`timescale 1ns/10ps
module psc_privilege_state_control_bench;
   import psc_pkg::*;
   logic clk, reset, wbCyc, wbStb, wbWe, wbAck, cpuReq;
   logic [3:0] wbSel;
   logic [7:0] wbAdr;
   logic [31:0] wbDatIn, wbDatOut;
   logic intAckIn, traceIn, trapIn, busErrorIn, addrErrorIn;
   logic handlerStartIn, progFetchIn, cpuSpaceIn, busCycleEn;
   logic supervisorOut, exceptionOut, haltedOut, stoppedOut;
   logic privViolationOut, resetDevicesOut;
   logic [2:0] accessSpaceCode;
   logic [1:0] activeStackOut;
   logic [15:0] codeErrs, codeChecks;
   int fail_count, cmp_count;

   psc_privilege_state_control psc_privilege_state_control_i (
      .clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatIn(wbDatIn),
      .wbDatOut(wbDatOut), .wbAck(wbAck), .intAckIn(intAckIn),
      .traceIn(traceIn), .trapIn(trapIn), .busErrorIn(busErrorIn),
      .addrErrorIn(addrErrorIn), .handlerStartIn(handlerStartIn),
      .progFetchIn(progFetchIn), .cpuSpaceIn(cpuSpaceIn),
      .accessSpaceCode(accessSpaceCode), .busCycleEn(busCycleEn),
      .supervisorOut(supervisorOut), .exceptionOut(exceptionOut),
      .haltedOut(haltedOut), .stoppedOut(stoppedOut),
      .privViolationOut(privViolationOut),
      .resetDevicesOut(resetDevicesOut), .activeStackOut(activeStackOut));

   psc_bus_partner psc_bus_partner_i (
      .clk(clk), .reset(reset), .cpuReq(cpuReq),
      .supervisorIn(supervisorOut), .exceptionIn(exceptionOut),
      .accessSpaceCode(accessSpaceCode), .progFetch(progFetchIn),
      .cpuSpace(cpuSpaceIn), .codeErrs(codeErrs), .codeChecks(codeChecks));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h", $time, what, got);
      end
   endtask : chk

   // one classic cycle; request held until ack is sampled high
   task automatic xfer(input logic we, input logic [7:0] adr,
         input logic [3:0] sel, input logic [31:0] dat,
         output logic [31:0] q);
      int n;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatIn <= dat;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1);
      // ack is due one cycle after the request is seen; only the
      // watchdog ends a wait that never gets an answer
      chk(n, 32'h2, "ack latency");
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask : xfer

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      xfer(1'b1, adr, 4'hF, dat, q);
   endtask : wr

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp,
         input string what);
      logic [31:0] q;
      xfer(1'b0, adr, 4'hF, 32'h0, q);
      chk(q, exp, what);
   endtask : rd

   task automatic cmd(input logic [3:0] op, input logic [15:0] v);
      wr(ADR_COMMAND, {12'h0, op, v});
   endtask : cmd

   task automatic stChk(input logic [2:0] st, input logic [6:0] cause);
      logic [31:0] q;
      xfer(1'b0, ADR_STATE, 4'hF, 32'h0, q);
      chk({22'h0, q[14:8], q[2:0]}, {22'h0, cause, st}, "state reg");
   endtask : stChk

   // one-cycle pulse: 0 int, 1 trace, 2 trap, 3 bus, 4 addr, 5 handler
   task automatic evt(input int k);
      intAckIn <= (k == 0);
      traceIn <= (k == 1);
      trapIn <= (k == 2);
      busErrorIn <= (k == 3);
      addrErrorIn <= (k == 4);
      handlerStartIn <= (k == 5);
      @(posedge clk);
      {intAckIn, traceIn, trapIn, busErrorIn, addrErrorIn} <= 5'h0;
      handlerStartIn <= 1'b0;
      @(posedge clk);
   endtask : evt

   task automatic do_reset;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   task automatic t_reset;
      cpuReq <= 1'b1;
      rd(ADR_STATUS_WORD, 32'h2700, "status");
      stChk(3'h1, 7'h0);
      chk({30'h0, activeStackOut}, 32'h1, "stack sel");
      rd(8'h40, 32'h0, "unmapped");
      wr(ADR_STATUS_WORD, 32'h0);
      rd(ADR_STATUS_WORD, 32'h2700, "ro status");
      cpuReq <= 1'b0;
   endtask : t_reset

   task automatic t_stacks;
      logic [31:0] q;
      wr(ADR_USER_STACK, 32'h1111_1111);
      wr(ADR_INT_STACK, 32'h2222_2222);
      wr(ADR_MASTER_STACK, 32'h3333_3333);
      rd(ADR_STACK_ALIAS, 32'h2222_2222, "alias int");
      cmd(OP_MOVE_TO_STATUS, 16'h3700);
      rd(ADR_STACK_ALIAS, 32'h3333_3333, "alias master");
      cmd(OP_RESET_DEVICES, 16'h0);
      chk({31'h0, resetDevicesOut}, 32'h1, "reset op");
      cmd(OP_XOR_TO_STATUS, 16'h1000);
      rd(ADR_STATUS_WORD, 32'h2700, "xor");
      cmd(OP_OR_TO_STATUS, 16'h1000);
      rd(ADR_STATUS_WORD, 32'h3700, "or");
      cmd(OP_AND_TO_STATUS, 16'hDFFF);
      rd(ADR_STATUS_WORD, 32'h1700, "and");
      chk({31'h0, supervisorOut}, 32'h0, "user level");
      chk({30'h0, activeStackOut}, 32'h0, "user sel");
      xfer(1'b1, ADR_STACK_ALIAS, 4'h3, 32'hAAAA_5555, q);
      rd(ADR_USER_STACK, 32'h1111_5555, "alias user");
   endtask : t_stacks

   task automatic t_priv;
      for (logic [3:0] op = 4'h1; op <= 4'h7; op++) begin
         cmd(op, 16'h2000);
         chk({31'h0, privViolationOut}, 32'h1, "violation");
         chk({31'h0, exceptionOut}, 32'h1, "entry");
         chk({30'h0, resetDevicesOut, stoppedOut}, 32'h0, "no run");
         rd(ADR_SAVED_STATUS, 32'h1700, "saved");
         rd(ADR_STATUS_WORD, 32'h3700, "super set");
         stChk(3'h2, 7'h20);
         evt(5);
         cmd(OP_RETURN_FROM_EXC, 16'h1700);
      end
      cmd(OP_SOFT_TRAP, 16'h0);
      chk({31'h0, privViolationOut}, 32'h0, "trap legal");
      stChk(3'h2, 7'h40);
      cmd(OP_AND_TO_STATUS, 16'h0);
      rd(ADR_STATUS_WORD, 32'h3700, "cmd in exc");
      evt(5);
      cmd(OP_RETURN_FROM_EXC, 16'h1700);
   endtask : t_priv

   task automatic t_events;
      for (int k = 0; k < 3; k++) begin
         evt(k);
         rd(ADR_STATUS_WORD, (k == 0) ? 32'h2700 : 32'h3700, "m");
         rd(ADR_SAVED_STATUS, 32'h1700, "saved ev");
         stChk(3'h2, 7'h01 << k);
         evt(1);
         chk({31'h0, exceptionOut}, 32'h1, "still exc");
         evt(5);
         chk({31'h0, exceptionOut}, 32'h0, "handler");
         cmd(OP_RETURN_FROM_EXC, 16'h1700);
      end
   endtask : t_events

   task automatic t_halt;
      evt(3);
      chk({30'h0, exceptionOut, haltedOut}, 32'h2, "bus err");
      evt(5);
      for (int k = 3; k < 5; k++) begin
         evt(2);
         evt(k);
         chk({31'h0, haltedOut}, 32'h1, "halt");
         chk({31'h0, busCycleEn}, 32'h0, "halt idle");
         evt(5);
         evt(0);
         stChk(3'h4, 7'h04);
         do_reset;
         chk({31'h0, haltedOut}, 32'h0, "restart");
         rd(ADR_STATUS_WORD, 32'h2700, "reset status");
         chk({30'h0, activeStackOut}, 32'h1, "reset stack");
      end
   endtask : t_halt

   task automatic t_stop;
      cmd(OP_STOP_WAIT, 16'h0);
      chk({30'h0, stoppedOut, busCycleEn}, 32'h2, "stop");
      chk({31'h0, haltedOut}, 32'h0, "not halt");
      cmd(OP_OR_TO_STATUS, 16'h1000);
      rd(ADR_STATUS_WORD, 32'h2700, "stopped cmd");
      evt(0);
      chk({30'h0, stoppedOut, exceptionOut}, 32'h1, "wake");
      evt(5);
   endtask : t_stop

   initial begin
      reset = 1'b1;
      {wbCyc, wbStb, wbWe, cpuReq} = 4'h0;
      wbSel = 4'h0;
      wbAdr = 8'h0;
      wbDatIn = 32'h0;
      {intAckIn, traceIn, trapIn, busErrorIn, addrErrorIn} = 5'h0;
      handlerStartIn = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      do_reset;
      t_reset;
      t_stacks;
      t_priv;
      t_events;
      t_halt;
      t_stop;
      chk({16'h0, codeErrs}, 32'h0, "space codes");
      chk({31'h0, codeChecks != 16'h0}, 32'h1, "codes seen");
      summarize;
   end

   // watchdog, well beyond the few hundred cycles the tests take
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      summarize;
   end
endmodule : psc_privilege_state_control_bench
